//--- hdl/hpp_pin_port.sv
`default_nettype none

module hpp_pin_port (
  input wire logic sys_clk,
  input wire logic rst,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // shared data and parity pins
  input wire hpp_pkg::hpp_pins_type pinIn,
  output hpp_pkg::hpp_pins_type pinOut,
  output hpp_pkg::hpp_pins_type pinOe,
  input wire logic extBusRequestSecondPin,
  // internal system bus side
  input wire logic [63:0] sysWriteData,
  input wire logic sysDriveEnable,
  input wire logic sysCapture,
  output logic [63:0] sysReadData,
  output logic busRequestSecond,
  output logic hostPortEnabled
);
  import hpp_pkg::*;

  typedef struct packed {
    hpp_pins_type syncFirst;
    hpp_pins_type syncSecond;
    logic brFirst;
    logic brSecond;
    hpp_host_state_type state;
    logic [CTRL_W-1:0] ctrl;
    logic [15:0] txData;
    logic txFull;
    logic [15:0] rxData;
    logic [3:0] rxAddr;
    logic rxFull;
    logic ackPrev;
    logic ackSeen;
    logic [LANES-1:0] parErr;
    logic [15:0] hostOut;
    logic hostOe;
    hpp_pins_type busOut;
    hpp_pins_type busOe;
    logic [63:0] readData;
    logic wbAck;
    logic [31:0] wbData;
  } hpp_state_type;

  hpp_state_type s;
  hpp_state_type next_s;

  // ==========================================================
  // combinational view of the synchronised pins
  hpp_pins_type p;
  logic hostEn;
  logic wideOnly;
  logic select;
  logic strobePol;
  logic dual;
  logic narrow;
  logic rdStrobe;
  logic wrStrobe;
  logic txReq;
  logic rxReq;
  logic reqSingle;
  logic ackActive;
  logic wbReq;
  logic wbWrite;
  logic wbRead;
  logic [31:0] statusWord;
  logic [15:0] hostStatus;

  always_comb begin
    p = s.syncSecond;
    hostEn = s.ctrl[CTRL_HOST_EN];
    wideOnly = s.ctrl[CTRL_WIDE_ONLY];
    select = p.data[PIN_SEL1] | p.data[PIN_SEL2];
    strobePol = p.data[PIN_STROBE_POL];
    dual = p.data[PIN_DUAL];
    narrow = p.data[PIN_NARROW];
    if (dual) begin
      rdStrobe = (p.data[PIN_DIR] == strobePol);
      wrStrobe = (p.data[PIN_STROBE] == strobePol);
    end else begin
      rdStrobe = (p.data[PIN_STROBE] == strobePol) & p.data[PIN_DIR];
      wrStrobe = (p.data[PIN_STROBE] == strobePol) & ~p.data[PIN_DIR];
    end
    txReq = s.txFull;
    rxReq = ~s.rxFull;
    reqSingle = txReq | rxReq;
    ackActive = (p.data[PIN_ACK] == s.ctrl[CTRL_ACK_POL]);
    wbReq = wb_cyc_i & wb_stb_i & ~s.wbAck;
    wbWrite = wbReq & wb_we_i;
    wbRead = wbReq & ~wb_we_i;
    statusWord = 32'h0;
    statusWord[ST_TXFULL] = s.txFull;
    statusWord[ST_RXFULL] = s.rxFull;
    statusWord[ST_ACKSEEN] = s.ackSeen;
    statusWord[ST_BUSREQ] = s.brSecond;
    statusWord[ST_STROBE_POL] = strobePol;
    statusWord[ST_DUAL] = dual;
    statusWord[ST_NARROW] = narrow;
    statusWord[ST_PARERR_LSB +: LANES] = s.parErr;
    hostStatus = statusWord[15:0];
  end

  // ==========================================================
  // next state
  always_comb begin
    next_s = s;
    // pins pass two flops before any logic reads them
    next_s.syncFirst = pinIn;
    next_s.syncSecond = s.syncFirst;
    next_s.brFirst = extBusRequestSecondPin;
    next_s.brSecond = s.brFirst;

    // host access sequencer; a strobe only counts while selected
    case (s.state)
      HPP_IDLE: begin
        if (hostEn && select && rdStrobe) begin
          next_s.state = HPP_READ;
          next_s.hostOe = 1'b1;
          if (p.data[HOST_ADDR_LSB +: 4] == HOST_REG_TX) begin
            next_s.hostOut = narrow ? {8'h00, s.txData[7:0]} : s.txData;
            next_s.txFull = 1'b0;
          end else begin
            next_s.hostOut = narrow ? {8'h00, hostStatus[7:0]} : hostStatus;
          end
        end else if (hostEn && select && wrStrobe) begin
          next_s.state = HPP_WRITE;
          next_s.rxData = narrow ? {8'h00, p.data[HOST_DATA_LSB +: 8]} : p.data[HOST_DATA_LSB +: 16];
          next_s.rxAddr = p.data[HOST_ADDR_LSB +: 4];
        end
      end
      HPP_READ: begin
        // release the lines as soon as the strobe or select goes away
        if (!(hostEn && select && rdStrobe)) begin
          next_s.state = HPP_IDLE;
          next_s.hostOe = 1'b0;
        end
      end
      HPP_WRITE: begin
        if (!(hostEn && select && wrStrobe)) begin
          next_s.state = HPP_IDLE;
        end
      end
      default: begin
        next_s.state = HPP_IDLE;
        next_s.hostOe = 1'b0;
      end
    endcase

    // acknowledge only matters with a single request line
    next_s.ackPrev = ackActive;

    // ==========================================================
    // wishbone slave: ack one cycle after the request, data registered
    next_s.wbAck = wbReq;
    next_s.wbData = 32'h0;
    if (wbRead) begin
      case (wb_adr_i)
        REG_CTRL: next_s.wbData = {{(32-CTRL_W){1'b0}}, s.ctrl};
        REG_STATUS: next_s.wbData = statusWord;
        REG_TXDATA: next_s.wbData = {16'h0, s.txData};
        REG_RXDATA: begin
          next_s.wbData = {12'h0, s.rxAddr, s.rxData};
          next_s.rxFull = 1'b0;
        end
        default: next_s.wbData = 32'h0;
      endcase
    end
    if (wbWrite) begin
      case (wb_adr_i)
        REG_CTRL: begin
          if (wb_sel_i[0]) begin
            next_s.ctrl = wb_dat_i[CTRL_W-1:0];
          end
        end
        REG_STATUS: begin
          // write one to clear sticky flags
          if (wb_sel_i[0] && wb_dat_i[ST_ACKSEEN]) begin
            next_s.ackSeen = 1'b0;
          end
          if (wb_sel_i[1]) begin
            next_s.parErr = s.parErr & ~wb_dat_i[ST_PARERR_LSB +: LANES];
          end
        end
        REG_TXDATA: begin
          if (wb_sel_i[0]) begin
            next_s.txData[7:0] = wb_dat_i[7:0];
          end
          if (wb_sel_i[1]) begin
            next_s.txData[15:8] = wb_dat_i[15:8];
          end
          next_s.txFull = 1'b1;
        end
        default: begin
        end
      endcase
    end

    // hardware sets come last so a set in the clearing cycle wins
    if (s.state == HPP_IDLE && hostEn && select && !rdStrobe && wrStrobe) begin
      next_s.rxFull = 1'b1;
    end
    if (hostEn && !s.ctrl[CTRL_DOUBLE_REQ] && ackActive && !s.ackPrev) begin
      next_s.ackSeen = 1'b1;
    end

    // ==========================================================
    // system data pins; undriven bits other than the host data lines are kept at zero so parity stays coherent
    next_s.busOut = '0;
    next_s.busOe = '0;
    for (int i = 0; i < SYS_W; i++) begin
      if (i < LOW_W) begin
        next_s.busOe.data[i] = sysDriveEnable;
      end else if (!hostEn) begin
        next_s.busOe.data[i] = sysDriveEnable & ((i < TOP_LSB) | wideOnly);
      end
      next_s.busOut.data[i] = next_s.busOe.data[i] & sysWriteData[i];
    end
    if (hostEn) begin
      // other upper pins are host inputs or reserved and are never driven
      for (int i = 0; i < 16; i++) begin
        next_s.busOut.data[HOST_DATA_LSB + i] = next_s.hostOut[i];
        next_s.busOe.data[HOST_DATA_LSB + i] = next_s.hostOe & (~narrow | (i < 8));
      end
      if (s.ctrl[CTRL_DOUBLE_REQ]) begin
        next_s.busOut.data[PIN_REQ] = ~s.ctrl[CTRL_REQ_OD] & (txReq == s.ctrl[CTRL_REQ_POL]);
        next_s.busOe.data[PIN_REQ] = ~s.ctrl[CTRL_REQ_OD] | (txReq != s.ctrl[CTRL_REQ_POL]);
        next_s.busOut.data[PIN_ACK] = ~s.ctrl[CTRL_REQ_OD] & (rxReq == s.ctrl[CTRL_REQ_POL]);
        next_s.busOe.data[PIN_ACK] = ~s.ctrl[CTRL_REQ_OD] | (rxReq != s.ctrl[CTRL_REQ_POL]);
      end else begin
        next_s.busOut.data[PIN_REQ] = ~s.ctrl[CTRL_REQ_OD] & (reqSingle == s.ctrl[CTRL_REQ_POL]);
        next_s.busOe.data[PIN_REQ] = ~s.ctrl[CTRL_REQ_OD] | (reqSingle != s.ctrl[CTRL_REQ_POL]);
      end
    end
    // odd parity per byte lane, driven with the system data; lanes 4 to 7 stay undriven while the host port is enabled
    for (int k = 0; k < LANES; k++) begin
      next_s.busOe.parity[k] = sysDriveEnable & ((k < HOST_LANE_FIRST) | ~hostEn);
      next_s.busOut.parity[k] = next_s.busOe.parity[k] & ~(^next_s.busOut.data[8*k +: 8]);
    end

    // receive side: capture data and check the other driver's parity
    if (sysCapture && !sysDriveEnable) begin
      next_s.readData = p.data;
      if (hostEn) begin
        next_s.readData[SYS_W-1:LOW_W] = '0;
      end else if (!wideOnly) begin
        next_s.readData[SYS_W-1:TOP_LSB] = '0;
      end
      for (int k = 0; k < LANES; k++) begin
        if (((k < HOST_LANE_FIRST) | ~hostEn) && !(^{p.data[8*k +: 8], p.parity[k]})) begin
          next_s.parErr[k] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.state <= HPP_IDLE;
      s.ctrl <= CTRL_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // outputs
  assign wb_ack_o = s.wbAck;
  assign wb_dat_o = s.wbData;
  assign pinOut = s.busOut;
  assign pinOe = s.busOe;
  assign sysReadData = s.readData;
  assign busRequestSecond = s.brSecond;
  assign hostPortEnabled = s.ctrl[CTRL_HOST_EN];

endmodule // hpp_pin_port

`default_nettype wire

//--- hdl/hpp_pkg.sv
// Operation
// - bus master drives shared data on writes, addressed slave drives it on reads
// - host port enabled: sixteen shared pins become tri-state host data lines
// - effective host select is the OR of both select inputs
// - single strobe: direction select plus one data strobe time each access
// - double strobe: separate read and write strobes, sampled as clean inputs
// - strobe active level follows the strobe polarity select pin
// - dual strobe select pin chooses single or separate strobe operation
// - single request: one request output, programmable polarity, driven or open-drain
// - double request: transmit and receive requests, each polarity and drive style
// - single request mode: host acknowledge sampled with programmable polarity
// - width select pin places host port in 8-bit or 16-bit mode
// - top three data bits carry data only in wide bus only mode
// - dedicated shared signals carry no data while the host port is enabled
// - driver of data sets each byte's parity for odd ones over its lane; host read data on lanes 4 and 5 goes out with no parity driven
// - host disabled: 64-bit system data; enabled: low word alone, 32-bit
// - every byte lane has its own odd parity pin set by driver; the port drives no parity on lanes 4 to 7 while the host port is enabled
`default_nettype none

package hpp_pkg;

  // ==========================================================
  // pin map of the shared upper data word
  localparam int SYS_W = 64;
  localparam int LANES = 8;
  localparam int LOW_W = 32;
  localparam int HOST_DATA_LSB = 32;
  localparam int HOST_ADDR_LSB = 48;
  localparam int PIN_SEL1 = 52;
  localparam int PIN_DIR = 53;
  localparam int PIN_STROBE = 54;
  localparam int PIN_REQ = 55;
  localparam int PIN_ACK = 56;
  localparam int PIN_STROBE_POL = 57;
  localparam int PIN_DUAL = 58;
  localparam int PIN_NARROW = 59;
  localparam int PIN_SEL2 = 60;
  localparam int TOP_LSB = 61;
  localparam int HOST_LANE_FIRST = 4;

  // ==========================================================
  // register offsets (byte addresses) and fields
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_TXDATA = 8'h08;
  localparam logic [7:0] REG_RXDATA = 8'h0c;
  localparam int CTRL_HOST_EN = 0;
  localparam int CTRL_WIDE_ONLY = 1;
  localparam int CTRL_REQ_POL = 2;
  localparam int CTRL_REQ_OD = 3;
  localparam int CTRL_DOUBLE_REQ = 4;
  localparam int CTRL_ACK_POL = 5;
  localparam int CTRL_W = 6;
  localparam logic [5:0] CTRL_RESET = 6'h00;
  localparam int ST_TXFULL = 0;
  localparam int ST_RXFULL = 1;
  localparam int ST_ACKSEEN = 2;
  localparam int ST_BUSREQ = 3;
  localparam int ST_STROBE_POL = 4;
  localparam int ST_DUAL = 5;
  localparam int ST_NARROW = 6;
  localparam int ST_PARERR_LSB = 8;
  localparam int RX_ADDR_LSB = 16;
  localparam logic [3:0] HOST_REG_TX = 4'h0;

  // ==========================================================
  // types
  typedef struct packed {
    logic [SYS_W-1:0] data;
    logic [LANES-1:0] parity;
  } hpp_pins_type;

  typedef enum logic [2:0] {
    HPP_IDLE = 3'b001,
    HPP_READ = 3'b010,
    HPP_WRITE = 3'b100
  } hpp_host_state_type;

endpackage

`default_nettype wire

//--- sim/hpp_host_model.sv
`default_nettype none
module hpp_host_model
  import hpp_pkg::*;
(
  input wire logic sys_clk,
  input wire hpp_pkg::hpp_pins_type pinOut,
  input wire hpp_pkg::hpp_pins_type pinOe,
  output hpp_pkg::hpp_pins_type pinIn
);
  hpp_pins_type farOut = '0;
  hpp_pins_type farOe = '0;
  hpp_pins_type last = '0;
  // released lines flip every cycle so stale data can never look valid
  assign pinIn = (pinOe & pinOut) | (~pinOe & farOe & farOut) | (~pinOe & ~farOe & ~last);
  always @(posedge sys_clk) last <= pinIn;
  task automatic setPins(input logic [63:0] d, input logic [63:0] oe, input logic [7:0] p, input logic [7:0] poe);
    @(posedge sys_clk);
    farOut <= {d, p};
    farOe <= {oe, poe};
  endtask
  // ==========================================================
  // one host access; strobes and select released together
  task automatic hostAccess(input logic rd, input logic dual, input logic pol, input logic [1:0] sel,
    input logic [3:0] a, input logic [15:0] wd, output logic [15:0] q);
    logic [63:0] d;
    d = '0;
    d[47:32] = wd;
    d[51:48] = a;
    d[PIN_SEL1] = sel[0];
    d[PIN_SEL2] = sel[1];
    d[PIN_DIR] = dual ? rd ~^ pol : rd;
    d[PIN_STROBE] = dual ? rd ^ pol : pol;
    d[PIN_STROBE_POL] = pol;
    d[PIN_DUAL] = dual;
    setPins(d, {16'h1fff, {16{!rd}}, 32'h0}, {2'b0, ~^wd[15:8], ~^wd[7:0], 4'h0}, {2'b0, {2{!rd}}, 4'h0});
    // a read waits for the lines to be driven; only the bench watchdog ends a hung read
    if (rd) begin
      while (!pinOe.data[HOST_DATA_LSB]) begin
        @(posedge sys_clk);
      end
    end else begin
      repeat (12) @(posedge sys_clk);
    end
    q = pinIn.data[47:32];
    d[PIN_SEL1] = 1'b0;
    d[PIN_SEL2] = 1'b0;
    d[PIN_DIR] = dual ? !pol : rd;
    d[PIN_STROBE] = !pol;
    setPins(d, {16'h1fff, 48'h0}, 8'h0, 8'h0);
    repeat (5) @(posedge sys_clk);
  endtask
endmodule // hpp_host_model
`default_nettype wire

//--- sim/hpp_pin_port_chk.sv
`default_nettype none
module hpp_chk
  import hpp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire hpp_pkg::hpp_pins_type pinIn,
  input wire hpp_pkg::hpp_pins_type pinOut,
  input wire hpp_pkg::hpp_pins_type pinOe,
  input wire logic extBusRequestSecondPin,
  input wire logic sysDriveEnable,
  input wire logic busRequestSecond,
  input wire logic hostPortEnabled
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // register bus
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("request not acked");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
  // ==========================================================
  // shared pins
  low_drive_a:
    assert property (1'b1 |=> pinOe.data[31:0] == {32{$past(sysDriveEnable)}}) else $error("low word drive wrong");
  lane0_odd_a:
    assert property (pinOe.parity[0] |-> ^{pinOut.parity[0], pinOut.data[7:0]}) else $error("lane 0 parity even");
  lane1_odd_a:
    assert property (pinOe.parity[1] |-> ^{pinOut.parity[1], pinOut.data[15:8]}) else $error("lane 1 parity even");
  host_quiet_a:
    assert property (hostPortEnabled && $past(hostPortEnabled) |-> pinOe.data[63:57] == 7'h0
      && pinOe.data[54:48] == 7'h0 && pinOe.parity[7:4] == 4'h0) else $error("host pins driven");
  host_read_sel_a:
    assert property ($rose(pinOe.data[HOST_DATA_LSB]) && hostPortEnabled
      |-> $past(pinIn.data[PIN_SEL1] || pinIn.data[PIN_SEL2], 3)) else $error("host data driven unselected");
  host_release_a:
    assert property (hostPortEnabled && $fell(pinIn.data[PIN_SEL1] || pinIn.data[PIN_SEL2])
      |-> ##[1:5] !pinOe.data[HOST_DATA_LSB]) else $error("host data not released");
  bus_request_a:
    assert property ($rose(extBusRequestSecondPin) |-> ##[2:4] busRequestSecond) else $error("bus request lost");
  cover property ($rose(pinOe.data[HOST_DATA_LSB]) && hostPortEnabled);
  cover property (busRequestSecond);
  cover property (wb_ack_o && wb_dat_o != 32'h0);
endmodule // hpp_chk
`default_nettype wire

//--- sim/hpp_pin_port_tb.sv
`default_nettype none
module hpp_pin_port_tb
  import hpp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [7:0] wbAdr = 8'h0;
  logic [3:0] wbSel = 4'h0;
  logic [31:0] wbDatW = 32'h0;
  logic [31:0] wbDatR;
  logic wbAck;
  hpp_pins_type pinIn;
  hpp_pins_type pinOut;
  hpp_pins_type pinOe;
  logic extReq = 1'b0;
  logic [63:0] sysWr = 64'h0;
  logic sysDrv = 1'b0;
  logic sysCap = 1'b0;
  logic [63:0] sysRd;
  logic busReq;
  logic hostEn;
  int errCount = 0;
  int compares = 0;
  logic [31:0] r;
  logic [15:0] q;
  localparam logic [63:0] D = 64'hf0e1d2c3b4a59687;
  always #2 sys_clk = ~sys_clk;
  hpp_pin_port i_hpp_pin_port (.sys_clk, .rst, .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .pinIn,
    .pinOut, .pinOe, .extBusRequestSecondPin(extReq), .sysWriteData(sysWr), .sysDriveEnable(sysDrv),
    .sysCapture(sysCap), .sysReadData(sysRd), .busRequestSecond(busReq), .hostPortEnabled(hostEn));
  hpp_host_model i_hpp_host_model (.sys_clk, .pinOut, .pinOe, .pinIn);
  // ==========================================================
  // helpers
  function automatic logic [7:0] oddPar(input logic [63:0] d);
    for (int k = 0; k < 8; k++) oddPar[k] = ~^d[8*k+:8];
  endfunction
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      errCount++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic testDone();
    $display("comparisons %0d mismatches %0d", compares, errCount);
    if (errCount == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    {wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatW} <= {2'b11, we, a, 4'hf, d};
    @(posedge sys_clk);
    // no local limit: a missing ack is caught by the watchdog
    while (wbAck !== 1'b1) begin
      @(posedge sys_clk);
    end
    r = wbDatR;
    {wbCyc, wbStb} <= 2'b00;
    @(posedge sys_clk);
  endtask
  // ==========================================================
  // scenarios
  task automatic tRegs();
    wb(0, REG_CTRL, 0);
    check(r, 0);
    wb(1, 8'h40, 32'hffffffff);
    wb(0, 8'h40, 0);
    check(r, 0);
  endtask
  task automatic tSysDrive(input logic wide);
    logic [63:0] m;
    m = {{3{wide}}, 61'h1fffffffffffffff};
    wb(1, REG_CTRL, {30'h0, wide, 1'b0});
    sysWr <= D;
    sysDrv <= 1'b1;
    repeat (2) @(posedge sys_clk);
    check(pinOe.data, m);
    check(pinOut.data & m, D & m);
    check({pinOe.parity, pinOut.parity}, {8'hff, oddPar(D & m)});
    sysDrv <= 1'b0;
  endtask
  task automatic tCapture();
    i_hpp_host_model.setPins(D, '1, oddPar(D) ^ 8'h01, 8'hff);
    sysCap <= 1'b1;
    repeat (6) @(posedge sys_clk);
    sysCap <= 1'b0;
    check(sysRd, D);
    wb(0, REG_STATUS, 0);
    check(r[15:8], 8'h01);
    wb(1, REG_STATUS, 32'hff04);
    i_hpp_host_model.setPins(64'h0200000000000000, {16'h1fff, 48'h0}, 8'h0, 8'h0);
  endtask
  task automatic tHost();
    wb(1, REG_CTRL, 32'h05);
    sysWr <= '1;
    sysDrv <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check({pinOe.data[63:32], pinOe.parity}, {32'h00800000, 8'h0f});
    check(pinOut.data[PIN_REQ], 1);
    sysDrv <= 1'b0;
    i_hpp_host_model.hostAccess(0, 0, 1, 2'b01, 4'h3, 16'hbeef, q);
    check(pinOut.data[PIN_REQ], 0);
    wb(0, REG_RXDATA, 0);
    check(r, 32'h0003beef);
    wb(1, REG_TXDATA, 32'h1234);
    i_hpp_host_model.hostAccess(1, 1, 0, 2'b10, 4'h0, 16'h0, q);
    check(q, 16'h1234);
    i_hpp_host_model.hostAccess(0, 0, 1, 2'b00, 4'h5, 16'h5555, q);
    wb(0, REG_STATUS, 0);
    check(r[1], 0);
  endtask
  task automatic tModes();
    // narrow write: only the low eight host lines reach the receive register
    i_hpp_host_model.setPins(64'h0a56beef00000000, {16'h1fff, 16'hffff, 32'h0}, 8'h0, 8'h0);
    repeat (6) @(posedge sys_clk);
    i_hpp_host_model.setPins(64'h0a00000000000000, {16'h1fff, 48'h0}, 8'h0, 8'h0);
    repeat (3) @(posedge sys_clk);
    wb(1'h0, REG_STATUS, 32'h0);
    check(r[ST_NARROW], 1'h1);
    wb(1'h0, REG_RXDATA, 32'h0);
    check(r, 32'h000600ef);
    // double request, open drain, active high: transmit idle pulls low, receive released
    wb(1'h1, REG_CTRL, 32'h1d);
    @(posedge sys_clk);
    check({pinOe.data[56:55], pinOut.data[56:55]}, 4'h4);
    wb(1'h1, REG_TXDATA, 32'h00a5);
    @(posedge sys_clk);
    check({pinOe.data[56:55], pinOut.data[56:55]}, 4'h0);
    // single request, open drain, acknowledge active high
    wb(1'h1, REG_CTRL, 32'h2d);
    @(posedge sys_clk);
    check(pinOe.data[PIN_REQ], 1'h0);
    i_hpp_host_model.setPins(64'h0300000000000000, {16'h1fff, 48'h0}, 8'h0, 8'h0);
    repeat (4) @(posedge sys_clk);
    wb(1'h0, REG_STATUS, 32'h0);
    check(r[ST_ACKSEEN], 1'h1);
    wb(1'h1, REG_STATUS, 32'h4);
    wb(1'h0, REG_STATUS, 32'h0);
    check(r[ST_ACKSEEN], 1'h0);
  endtask
  task automatic tBusReq();
    extReq <= 1'b1;
    repeat (5) @(posedge sys_clk);
    check(busReq, 1);
    wb(0, REG_STATUS, 0);
    check(r[ST_BUSREQ], 1);
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    tRegs();
    tSysDrive(0);
    tSysDrive(1);
    tCapture();
    tHost();
    tModes();
    tBusReq();
    testDone();
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    errCount++;
    testDone();
  end
endmodule // hpp_pin_port_tb
bind hpp_pin_port hpp_chk i_hpp_chk (.sys_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .pinIn,
  .pinOut, .pinOe, .extBusRequestSecondPin, .sysDriveEnable, .busRequestSecond, .hostPortEnabled);
`default_nettype wire
